// File: shared/dcf_pkg.sv
// shared constants, carrier types and enumerations of the dual clock fifo block
// Operation
// - 9-bit words stored on enabled write edges
// - array depth 16384 or 32768, pointers wrap
// - one reference clock, ratio strap only reported, pins synchronised
// - standard mode needs explicit read for output
// - fall-through shows first word without read
// - mode sampled from pin during full reset
// - flag meaning follows selected timing mode
// - half-full fixed at half depth, both modes
// - almost flags have independent programmable thresholds
// - defaults 127 or 1023 chosen at reset
// - load select picks method, flags follow defaults
// - serial shift when serial and load enabled
// - parallel load from data bus replaces write
// - threshold readback on output with load select
// - full reset clears pointers, recomputes flags
// - partial reset keeps mode, method and thresholds
// - retransmit returns read pointer to start
// - idle ten cycles enters low power
// - write, read or serial load enable, reset or retransmit leaves low power immediately
// - ready outputs can drive cascaded enables
// - output enable high off releases data bus
// - both resets clear output data register
// - almost-empty low below n, high above
// - almost-full low below m, high above
// - after reset mode pin is serial input
package dcf_pkg;
  // ==========================================
  // array geometry
  localparam bit BIG_VARIANT = 1'b0;                    // 0 builds the smaller depth variant
  localparam int DATA_W = 9;                            // word width
  localparam int DEPTH = BIG_VARIANT ? 32768 : 16384;   // words in the array
  localparam int ADDR_W = BIG_VARIANT ? 15 : 14;        // array index width
  localparam int PTR_W = ADDR_W + 1;                    // pointer with wrap bit
  localparam int THR_W = 16;                            // threshold and count width
  localparam logic [THR_W-1:0] DEPTH_CNT = THR_W'(DEPTH);
  localparam logic [THR_W-1:0] HALF_CNT = THR_W'(DEPTH / 2);
  // ==========================================
  // threshold defaults and load sequencing
  localparam logic [THR_W-1:0] THR_DEF_SMALL = 16'h007F; // load select low at full reset
  localparam logic [THR_W-1:0] THR_DEF_LARGE = 16'h03FF; // load select high at full reset
  localparam logic [1:0] PAR_AE_LO = 2'h0;              // parallel word slots, empty first
  localparam logic [1:0] PAR_AE_HI = 2'h1;
  localparam logic [1:0] PAR_AF_LO = 2'h2;
  localparam logic [1:0] PAR_AF_HI = 2'h3;
  localparam int LO_W = 9;                              // bits carried by a low slot
  localparam int HI_W = THR_W - LO_W;                   // bits carried by a high slot
  // ==========================================
  // power down timing
  localparam logic [3:0] IDLE_CYCLES = 4'hA;            // idle edges before low power
  // ==========================================
  // register map on the apb slave
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_THRESH = 12'h008;
  localparam int CTRL_APD_BIT = 0;                      // auto power down enable
  localparam logic CTRL_APD_RST = 1'b1;
  localparam int STAT_MODE_BIT = 16;
  localparam int STAT_METHOD_BIT = 17;
  localparam int STAT_LOWPWR_BIT = 18;
  localparam int STAT_RATIO_BIT = 19;
  localparam int THRESH_AF_LSB = 16;
  // ==========================================
  // enumerations
  typedef enum logic [1:0] {MODE_STD = 2'b01, MODE_FALL_THROUGH_MODE = 2'b10} dcf_mode_t;
  typedef enum logic [1:0] {METH_PAR = 2'b01, METH_SER = 2'b10} dcf_method_t;
  // ==========================================
  // carriers
  typedef struct packed {
    logic fullResetN;
    logic partialResetN;
    logic retransmitRequestN;
    logic writeEnableN;
    logic readEnableN;
    logic serialLoadEnableN;
    logic thresholdLoadSelectN;
    logic outputDriveEnableN;
    logic modeSelectSerialInput;
    logic clockRatioSelect;
    logic [DATA_W-1:0] dataInBus;
  } dcf_pins_t;
  typedef struct packed {
    logic emptyOrOutputReadyFlag;
    logic fullOrInputReadyFlag;
    logic halfFullFlag;
    logic almostEmptyFlag;
    logic almostFullFlag;
  } dcf_flags_t;
  // idle level of every pin, active-low controls released
  localparam dcf_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 9'h000};
  localparam dcf_flags_t FLAGS_RST = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
endpackage

// File: verilog/dcf_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
module dcf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // first stage, read only by the second stage
  logic [W-1:0] stage1;
  // ==========================================
  // synchroniser chain
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// File: verilog/dcf_mem.sv
// flip-flop storage array, one write port and an indexed read
`timescale 1ns/1ns
module dcf_mem (
  input wire logic ref_clk,
  input wire logic wrEn,
  input wire logic [dcf_pkg::ADDR_W-1:0] wrAddr,
  input wire logic [dcf_pkg::DATA_W-1:0] wrData,
  input wire logic [dcf_pkg::ADDR_W-1:0] rdAddr,
  output logic [dcf_pkg::DATA_W-1:0] rdData
);
  // storage, no reset: contents are don't care until written
  logic [dcf_pkg::DATA_W-1:0] store [dcf_pkg::DEPTH];
  // ==========================================
  // write port
  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end
  // read is combinational, the top registers it
  assign rdData = store[rdAddr];
endmodule

// File: verilog/dcf_fifo.sv
// top of the fifo: pin sync, pointers, flags, threshold programming, power idle, apb status
`timescale 1ns/1ns
module dcf_fifo (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [dcf_pkg::DATA_W-1:0] dataInBus,
  input wire logic fullResetN,
  input wire logic partialResetN,
  input wire logic retransmitRequestN,
  input wire logic writeEnableN,
  input wire logic readEnableN,
  input wire logic serialLoadEnableN,
  input wire logic thresholdLoadSelectN,
  input wire logic outputDriveEnableN,
  input wire logic modeSelectSerialInput,
  input wire logic clockRatioSelect,
  output logic [dcf_pkg::DATA_W-1:0] dataOutBus,
  output logic dataOutBusOe,
  output dcf_pkg::dcf_flags_t flags,
  output logic lowPowerIdle,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ==========================================
  // pin synchronisation
  dcf_pkg::dcf_pins_t pinsRaw; // pins gathered into one carrier
  dcf_pkg::dcf_pins_t pins;    // pins after two flops
  assign pinsRaw = '{fullResetN, partialResetN, retransmitRequestN, writeEnableN, readEnableN,
                     serialLoadEnableN, thresholdLoadSelectN, outputDriveEnableN,
                     modeSelectSerialInput, clockRatioSelect, dataInBus};
  // data rides with its enable so both arrive aligned
  dcf_sync #(
    .W($bits(dcf_pkg::dcf_pins_t)),
    .RST_VAL(dcf_pkg::PINS_IDLE)
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din(pinsRaw),
    .dout(pins)
  );

  // ==========================================
  // state
  logic [dcf_pkg::PTR_W-1:0] wrPtr;         // write pointer with wrap bit
  logic [dcf_pkg::PTR_W-1:0] rdPtr;         // read pointer with wrap bit
  logic outValid;                           // fall-through output register holds a word
  dcf_pkg::dcf_mode_t mode;                 // timing mode
  dcf_pkg::dcf_method_t method;             // threshold programming method
  logic [dcf_pkg::THR_W-1:0] aeThr;         // almost-empty threshold n
  logic [dcf_pkg::THR_W-1:0] afThr;         // almost-full threshold m
  logic [1:0] parIdx;                       // next parallel slot to load
  logic [4:0] serIdx;                       // next serial bit position
  logic [1:0] rdThrIdx;                     // next slot to read back
  logic [3:0] idleCnt;                      // idle edges seen
  logic apdEn;                              // software enable for auto power down

  // ==========================================
  // decode of the synchronised controls, all active low
  logic fullRst;
  logic partRst;
  logic anyRst;
  logic retrans;
  logic isFwft;
  logic isSerial;
  assign fullRst = !pins.fullResetN;
  assign partRst = !pins.partialResetN;
  assign anyRst = fullRst || partRst;
  assign retrans = !pins.retransmitRequestN;
  assign isFwft = (mode == dcf_pkg::MODE_FALL_THROUGH_MODE);
  assign isSerial = (method == dcf_pkg::METH_SER);

  // ==========================================
  // occupancy
  logic [dcf_pkg::PTR_W-1:0] memCount;      // words in the array
  logic memEmpty;
  logic memFull;
  logic [dcf_pkg::THR_W-1:0] totalCount;    // array plus fall-through output word
  logic [dcf_pkg::THR_W-1:0] freeCount;     // free array locations
  assign memCount = wrPtr - rdPtr;
  assign memEmpty = (memCount == '0);
  assign memFull = (memCount == dcf_pkg::PTR_W'(dcf_pkg::DEPTH));
  assign totalCount = dcf_pkg::THR_W'(memCount) + dcf_pkg::THR_W'(outValid);
  assign freeCount = dcf_pkg::DEPTH_CNT - dcf_pkg::THR_W'(memCount);

  // ==========================================
  // request qualification
  logic wrReq;
  logic rdReq;
  logic thrWrite;
  logic serShift;
  logic thrRead;
  logic wrDo;
  logic stdRead;
  logic fwftLoad;
  logic fwftDrain;
  logic memPop;
  // load select low steers the enables to the thresholds
  assign wrReq = !pins.writeEnableN && pins.thresholdLoadSelectN;
  assign rdReq = !pins.readEnableN && pins.thresholdLoadSelectN;
  assign thrWrite = !pins.writeEnableN && !pins.thresholdLoadSelectN && !isSerial && !anyRst;
  assign serShift = !pins.serialLoadEnableN && !pins.thresholdLoadSelectN && isSerial && !anyRst;
  assign thrRead = !pins.readEnableN && !pins.thresholdLoadSelectN && !anyRst;
  assign wrDo = wrReq && !memFull && !anyRst;
  assign stdRead = !isFwft && rdReq && !memEmpty;
  // fall-through refills its output register on its own
  assign fwftLoad = isFwft && !memEmpty && (!outValid || rdReq) && !thrRead;
  assign fwftDrain = isFwft && rdReq && outValid && memEmpty;
  assign memPop = (stdRead || fwftLoad) && !anyRst && !retrans;

  // ==========================================
  // storage array
  logic [dcf_pkg::DATA_W-1:0] memRdData;
  dcf_mem u_mem (
    .ref_clk(ref_clk),
    .wrEn(wrDo),
    .wrAddr(wrPtr[dcf_pkg::ADDR_W-1:0]),
    .wrData(pins.dataInBus),
    .rdAddr(rdPtr[dcf_pkg::ADDR_W-1:0]),
    .rdData(memRdData)
  );

  // ==========================================
  // write pointer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr <= '0;
    end else if (anyRst) begin
      wrPtr <= '0;
    end else if (wrDo) begin
      wrPtr <= wrPtr + 1'b1;
    end
  end

  // ==========================================
  // read pointer
  // retransmit restarts at the first word still owned by the current lap;
  // a limitation: after an even number of exact laps the restart sees an empty array
  logic [dcf_pkg::PTR_W-1:0] rtPtr;
  assign rtPtr = (wrPtr[dcf_pkg::ADDR_W-1:0] == '0) ? '0 : {wrPtr[dcf_pkg::ADDR_W], {dcf_pkg::ADDR_W{1'b0}}};
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdPtr <= '0;
    end else if (anyRst) begin
      rdPtr <= '0;
    end else if (retrans) begin
      rdPtr <= rtPtr;
    end else if (memPop) begin
      rdPtr <= rdPtr + 1'b1;
    end
  end

  // ==========================================
  // threshold readback selection
  logic [dcf_pkg::DATA_W-1:0] thrPiece;
  assign thrPiece = (rdThrIdx == dcf_pkg::PAR_AE_LO) ? aeThr[dcf_pkg::LO_W-1:0] :
                    (rdThrIdx == dcf_pkg::PAR_AE_HI) ? dcf_pkg::DATA_W'(aeThr[dcf_pkg::THR_W-1:dcf_pkg::LO_W]) :
                    (rdThrIdx == dcf_pkg::PAR_AF_LO) ? afThr[dcf_pkg::LO_W-1:0] :
                    dcf_pkg::DATA_W'(afThr[dcf_pkg::THR_W-1:dcf_pkg::LO_W]);

  // ==========================================
  // output data register, also the bus value
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dataOutBus <= '0;
    end else if (anyRst) begin
      dataOutBus <= '0;
    end else if (thrRead) begin
      dataOutBus <= thrPiece;
    end else if (memPop) begin
      dataOutBus <= memRdData;
    end
  end

  // fall-through valid marker
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      outValid <= 1'b0;
    end else if (anyRst || retrans) begin
      outValid <= 1'b0;
    end else if (memPop && isFwft) begin
      outValid <= 1'b1;
    end else if (fwftDrain) begin
      outValid <= 1'b0;
    end
  end

  // output drive follows its own pin, not the reads
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dataOutBusOe <= 1'b0;
    end else begin
      dataOutBusOe <= !pins.outputDriveEnableN;
    end
  end

  // ==========================================
  // straps caught while full reset is held
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode <= dcf_pkg::MODE_STD;
      method <= dcf_pkg::METH_SER;
    end else if (fullRst) begin
      mode <= pins.modeSelectSerialInput ? dcf_pkg::MODE_FALL_THROUGH_MODE : dcf_pkg::MODE_STD;
      method <= pins.thresholdLoadSelectN ? dcf_pkg::METH_SER : dcf_pkg::METH_PAR;
    end
  end

  // ==========================================
  // load sequencing counters, kept by partial reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      parIdx <= '0;
      serIdx <= '0;
      rdThrIdx <= '0;
    end else if (fullRst) begin
      parIdx <= '0;
      serIdx <= '0;
      rdThrIdx <= '0;
    end else begin
      if (thrWrite) begin
        parIdx <= parIdx + 1'b1;
      end
      if (serShift) begin
        serIdx <= serIdx + 1'b1;
      end
      if (thrRead) begin
        rdThrIdx <= rdThrIdx + 1'b1;
      end
    end
  end

  // ==========================================
  // almost-empty threshold
  logic [dcf_pkg::THR_W-1:0] thrDefault;
  assign thrDefault = pins.thresholdLoadSelectN ? dcf_pkg::THR_DEF_LARGE : dcf_pkg::THR_DEF_SMALL;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aeThr <= dcf_pkg::THR_DEF_LARGE;
    end else if (fullRst) begin
      aeThr <= thrDefault;
    end else if (thrWrite && parIdx == dcf_pkg::PAR_AE_LO) begin
      aeThr[dcf_pkg::LO_W-1:0] <= pins.dataInBus;
    end else if (thrWrite && parIdx == dcf_pkg::PAR_AE_HI) begin
      aeThr[dcf_pkg::THR_W-1:dcf_pkg::LO_W] <= pins.dataInBus[dcf_pkg::HI_W-1:0];
    end else if (serShift && !serIdx[4]) begin
      aeThr[serIdx[3:0]] <= pins.modeSelectSerialInput;
    end
  end

  // almost-full threshold
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      afThr <= dcf_pkg::THR_DEF_LARGE;
    end else if (fullRst) begin
      afThr <= thrDefault;
    end else if (thrWrite && parIdx == dcf_pkg::PAR_AF_LO) begin
      afThr[dcf_pkg::LO_W-1:0] <= pins.dataInBus;
    end else if (thrWrite && parIdx == dcf_pkg::PAR_AF_HI) begin
      afThr[dcf_pkg::THR_W-1:dcf_pkg::LO_W] <= pins.dataInBus[dcf_pkg::HI_W-1:0];
    end else if (serShift && serIdx[4]) begin
      afThr[serIdx[3:0]] <= pins.modeSelectSerialInput;
    end
  end

  // ==========================================
  // flag computation, pin levels active low
  logic fullPin;
  logic emptyPin;
  always_comb begin
    case (mode)
      dcf_pkg::MODE_STD: begin
        fullPin = !memFull;   // low while full
        emptyPin = !memEmpty; // low while empty
      end
      dcf_pkg::MODE_FALL_THROUGH_MODE: begin
        fullPin = memFull;    // low while a write fits
        emptyPin = !outValid; // low while a word waits
      end
      default: begin
        fullPin = 1'b1;
        emptyPin = 1'b0;
      end
    endcase
  end
  dcf_pkg::dcf_flags_t next_flags;
  assign next_flags.fullOrInputReadyFlag = fullPin;
  assign next_flags.emptyOrOutputReadyFlag = emptyPin;
  assign next_flags.halfFullFlag = !(totalCount > dcf_pkg::HALF_CNT);
  assign next_flags.almostEmptyFlag = (totalCount > aeThr);
  assign next_flags.almostFullFlag = (freeCount > afThr);

  // flags lag state by one edge; write and read gating use the state itself
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flags <= dcf_pkg::FLAGS_RST;
    end else begin
      flags <= next_flags;
    end
  end

  // ==========================================
  // automatic power down
  // nothing is gated by the idle state, so leaving it costs no latency
  logic activity;
  assign activity = !pins.writeEnableN || !pins.readEnableN || !pins.serialLoadEnableN || anyRst || retrans;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idleCnt <= '0;
      lowPowerIdle <= 1'b0;
    end else if (activity || !apdEn) begin
      idleCnt <= '0;
      lowPowerIdle <= 1'b0;
    end else if (idleCnt != dcf_pkg::IDLE_CYCLES - 1'b1) begin
      idleCnt <= idleCnt + 1'b1;
    end else begin
      lowPowerIdle <= 1'b1;
    end
  end

  // ==========================================
  // apb slave, one wait-free access phase
  logic apbSetup;
  logic apbWrite;
  logic hitCtrl;
  logic hitStatus;
  logic hitThresh;
  logic [31:0] readMux;
  assign apbSetup = psel && !penable && !pready;
  assign apbWrite = psel && penable && pready && pwrite;
  assign hitCtrl = (paddr == dcf_pkg::ADDR_CTRL);
  assign hitStatus = (paddr == dcf_pkg::ADDR_STATUS);
  assign hitThresh = (paddr == dcf_pkg::ADDR_THRESH);
  assign readMux = hitCtrl ? 32'(apdEn) :
                   hitStatus ? (32'(totalCount) |
                                (32'(isFwft) << dcf_pkg::STAT_MODE_BIT) |
                                (32'(isSerial) << dcf_pkg::STAT_METHOD_BIT) |
                                (32'(lowPowerIdle) << dcf_pkg::STAT_LOWPWR_BIT) |
                                (32'(pins.clockRatioSelect) << dcf_pkg::STAT_RATIO_BIT)) :
                   hitThresh ? ((32'(afThr) << dcf_pkg::THRESH_AF_LSB) | 32'(aeThr)) :
                   32'h0000_0000;

  // answer one cycle after setup
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apbSetup;
      prdata <= apbSetup && !pwrite ? readMux : 32'h0000_0000;
      pslverr <= apbSetup && !(hitCtrl || hitStatus || hitThresh);
    end
  end

  // control register write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      apdEn <= dcf_pkg::CTRL_APD_RST;
    end else if (apbWrite && hitCtrl) begin
      apdEn <= pwdata[dcf_pkg::CTRL_APD_BIT];
    end
  end
endmodule

// File: dv/dcf_fifo_sva.sv
// concurrent checks on the fifo top ports
`timescale 1ns/1ns
module dcf_fifo_sva (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic fullResetN,
  input wire logic partialResetN,
  input wire logic retransmitRequestN,
  input wire logic writeEnableN,
  input wire logic readEnableN,
  input wire logic serialLoadEnableN,
  input wire logic outputDriveEnableN,
  input wire logic [dcf_pkg::DATA_W-1:0] dataOutBus,
  input wire logic dataOutBusOe,
  input wire dcf_pkg::dcf_flags_t flags,
  input wire logic lowPowerIdle,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr
);
  // ==========================================
  // helper: run length of released controls
  logic [4:0] idleCnt; // saturates so it never wraps back
  logic [4:0] next_idleCnt;
  logic quiet; // write, read and serial load enables, both resets and retransmit released
  assign quiet = &{fullResetN, partialResetN, retransmitRequestN, writeEnableN, readEnableN, serialLoadEnableN};
  assign next_idleCnt = !quiet ? 5'h00 : (idleCnt == 5'h1F) ? idleCnt : idleCnt + 5'h01;
  // counter cleared with the block reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) idleCnt <= 5'h00;
    else idleCnt <= next_idleCnt;
  end
  // ==========================================
  // assertions, pin paths take three edges
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  oe_drive_a: assert property (!outputDriveEnableN [*4] |-> dataOutBusOe)
    else $error("output bus not driven");
  oe_release_a: assert property (outputDriveEnableN [*4] |-> !dataOutBusOe)
    else $error("output bus driven while disabled");
  full_reset_a: assert property (!fullResetN [*4] |-> dataOutBus == '0 && flags.halfFullFlag)
    else $error("full reset left output or flags");
  part_reset_a: assert property (!partialResetN [*4] |-> dataOutBus == '0 && !flags.almostEmptyFlag)
    else $error("partial reset left output or flags");
  // the block counts pin levels two edges late, so compare with the count two edges back
  idle_entry_a: assert property ($rose(lowPowerIdle) |-> $past(idleCnt, 2) >= 5'h0A)
    else $error("low power entered too early");
  wake_up_a: assert property (lowPowerIdle && $fell(readEnableN) |-> ##[1:4] !lowPowerIdle)
    else $error("low power not left");
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("apb answer late");
  apb_error_a: assert property (psel && !penable && paddr > 12'h008 |=> pslverr)
    else $error("unmapped access not refused");
  apb_ok_a: assert property (psel && !penable && paddr <= 12'h008 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  cover property ($rose(lowPowerIdle));
  cover property (pready && pslverr);
  cover property ($rose(dataOutBusOe));
endmodule

// File: dv/dcf_pin_writer.sv
// writer-side partner: drives write enable and data pins from bench requests
`timescale 1ns/1ns
module dcf_pin_writer (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic req,
  input wire logic [dcf_pkg::DATA_W-1:0] word,
  output logic writeEnableN,
  output logic [dcf_pkg::DATA_W-1:0] dataInBus,
  output logic clockRatioSelect
);
  // one clock for both sides, so the ratio strap stays low
  assign clockRatioSelect = 1'b0;
  // idle data toggles so a stale word never looks valid
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      writeEnableN <= 1'b1;
      dataInBus <= '0;
    end else begin
      writeEnableN <= !req;
      dataInBus <= req ? word : ~dataInBus;
    end
  end
endmodule

// File: dv/dcf_fifo_test.sv
// self-checking bench for the dual clock fifo top
`timescale 1ns/1ns
module dual_clock_fifo_with_flags_test;
  logic ref_clk = 1'b0;
  logic nrst, fullResetN, partialResetN, retransmitRequestN, writeEnableN, readEnableN, req;
  logic serialLoadEnableN, thresholdLoadSelectN, outputDriveEnableN, modeSelectSerialInput, clockRatioSelect;
  logic [dcf_pkg::DATA_W-1:0] dataInBus, dataOutBus, word;
  logic dataOutBusOe, lowPowerIdle, psel, penable, pwrite, pready, pslverr, err;
  dcf_pkg::dcf_flags_t flags;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] seed = 16'h3B6F; // fixed start for repeatable data
  logic [8:0] q[$]; // words written, in order
  int failures = 0;
  int check_count = 0;
  dcf_fifo i_dut (.*);
  dcf_pin_writer i_wr (.*);
  always #4 ref_clk = ~ref_clk;
  // ==========================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // standard-mode flag levels for a stored count
  function automatic dcf_pkg::dcf_flags_t exp_flags(input int cnt, input int thr);
    return '{cnt != 0, cnt != dcf_pkg::DEPTH, cnt <= dcf_pkg::DEPTH / 2, cnt > thr, dcf_pkg::DEPTH - cnt > thr};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // apb transfer; signals move just after a rising edge, pready and data are taken at the edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // full reset with mode and load-select straps
  task automatic fr(input logic m, input logic ld);
    @(posedge ref_clk);
    {fullResetN, modeSelectSerialInput, thresholdLoadSelectN} <= {1'b0, m, ld};
    tick(4);
    {fullResetN, modeSelectSerialInput, thresholdLoadSelectN} <= 3'b101;
    tick(6);
  endtask
  task automatic wr(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      seed = lfsr(seed);
      req <= 1'b1;
      word <= seed[8:0];
      q.push_back(seed[8:0]);
    end
    @(posedge ref_clk);
    req <= 1'b0;
  endtask
  task automatic rd1;
    @(posedge ref_clk);
    readEnableN <= 1'b0;
    @(posedge ref_clk);
    readEnableN <= 1'b1;
    tick(5);
  endtask
  // ==========================================
  // main sequence
  initial begin
    {nrst, fullResetN, partialResetN, retransmitRequestN, readEnableN, serialLoadEnableN} = 6'h1F;
    {thresholdLoadSelectN, outputDriveEnableN, modeSelectSerialInput, req, word} = {3'b110, 10'h000};
    {psel, penable, pwrite, paddr, pwdata} = '0;
    tick(8);
    nrst <= 1'b1;
    chk(dataOutBusOe, 0);
    fr(1'b0, 1'b1);
    chk(flags, exp_flags(0, 1023));
    apb(1'b0, dcf_pkg::ADDR_CTRL, 0);
    chk(rd, 1);
    wr(5);
    tick(6);
    chk(flags, exp_flags(5, 1023));
    chk(dataOutBus, 0);
    apb(1'b0, dcf_pkg::ADDR_STATUS, 0);
    chk(rd, 32'h0002_0005);
    for (int i = 0; i < 5; i++) begin
      rd1();
      chk(dataOutBus, q[i]);
    end
    rd1();
    chk(dataOutBus, q[4]);
    retransmitRequestN <= 1'b0;
    tick(1);
    retransmitRequestN <= 1'b1;
    tick(5);
    rd1();
    chk(dataOutBus, q[0]);
    partialResetN <= 1'b0;
    tick(4);
    partialResetN <= 1'b1;
    tick(5);
    chk(dataOutBus, 0);
    chk(flags, exp_flags(0, 1023));
    apb(1'b0, dcf_pkg::ADDR_STATUS, 0);
    chk(rd, 32'h0002_0000);
    tick(14);
    chk(lowPowerIdle, 1);
    rd1();
    chk(lowPowerIdle, 0);
    outputDriveEnableN <= 1'b0;
    tick(4);
    chk(dataOutBusOe, 1);
    thresholdLoadSelectN <= 1'b0;
    rd1();
    chk(dataOutBus, 9'h1FF);
    thresholdLoadSelectN <= 1'b1;
    apb(1'b0, 12'h00C, 0);
    chk(err, 1);
    fr(1'b1, 1'b0);
    wr(1);
    tick(6);
    chk(dataOutBus, q[5]);
    chk(flags.emptyOrOutputReadyFlag, 0);
    apb(1'b0, dcf_pkg::ADDR_STATUS, 0);
    chk(rd, 32'h0001_0001);
    thresholdLoadSelectN <= 1'b0;
    wr(1);
    tick(3);
    thresholdLoadSelectN <= 1'b1;
    apb(1'b0, dcf_pkg::ADDR_THRESH, 0);
    chk(rd, {16'h007F, 7'h00, q[6]});
    close_out();
  end
endmodule
bind dcf_fifo dcf_fifo_sva i_sva (.*);
